// ### verilog/arf_formatter.sv
// Converter result formatter with AXI4-Lite register access and result-ready interrupt.
// Assumes raw codes arrive from converter logic on clk with a one-cycle sample strobe.
//
// Summary of operation
// - Every finished outcome lands in a 16-bit software-readable result register.
// - Single-ended codes are unsigned, 4096 steps at 12 bits, 1024 at 10 bits.
// - Differential codes are two's complement, 2048 or 512 steps per polarity.
// - Differential results narrower than 16 bits get the sign copied upward.
// - Default right alignment puts the eight lowest result bits in the low byte.
// - Left alignment set moves the eight top result bits into the high byte.
// - Left-aligned single 12-bit sample sits in bits 15:4, bits 3:0 zero.
// - Single-ended 12-bit input above reference yields 0xFFF.
// - Single-ended input below ground yields 0x000.
// - Differential 12-bit overrange positive clamps to 0x7FF.
// - Differential 12-bit overrange negative clamps to 0x800.
// - Several consecutive samples are summed, count set by the select field.
// - Above 16 samples, low sum bits are dropped so the result fits 16 bits.
// - Accumulator clears to zero at the start of every accumulated conversion.
// - On completion the formatted value is stored and the ready flag set.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module arf_formatter #(
	parameter int COUNT_SEL_MAX = 6
) (
	input  wire logic        clk,
	input  wire logic        reset,
	// Raw converter sample: one-cycle strobe with code and range flags
	input  wire logic        sample_valid,
	input  wire logic        sample_first,
	input  wire logic [11:0] sample_code,
	input  wire logic        sample_over,
	input  wire logic        sample_under,
	// Configuration seen by the converter sequencer, then result-ready flag and interrupt
	output logic             differential_select,
	output logic             resolution_select,
	output logic [2:0]       accumulation_count_select,
	output logic             result_ready_flag,
	output logic             irq,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import arf_pkg::*;

	// Select field is three bits and the sample counter eight, so 2**7 samples at most
	if (COUNT_SEL_MAX < 0 || COUNT_SEL_MAX > 7) begin : gen_bad_count_max
		$error("COUNT_SEL_MAX out of range");
	end

	// Registered state
	logic [2:0]        ctla_r;
	logic [2:0]        count_r;
	logic [15:0]       result_r;
	logic [IRQ_W-1:0]  status_r;
	logic [IRQ_W-1:0]  enable_r;
	logic [22:0]       acc_r;
	logic [7:0]        done_cnt_r;
	logic [11:0]       aw_addr_r;
	logic              aw_have_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              w_have_r;

	// Decoded controls and next-state helpers
	logic              diff;
	logic              left;
	logic              res10;
	logic [11:0]       clamped;
	logic signed [12:0] sample_ext;
	logic [22:0]       acc_nxt;
	logic [7:0]        target;
	logic              last;
	logic [15:0]       result_nxt;
	logic              wr_fire;
	logic [IRQ_W-1:0]  set_ev;
	logic [IRQ_W-1:0]  clr_ev;
	logic [2:0]        left_shift;

	// Fields of control A
	assign diff  = ctla_r[CTLA_DIFF_BIT];
	assign left  = ctla_r[CTLA_LEFT_BIT];
	assign res10 = ctla_r[CTLA_RES10_BIT];

	// Clamp overrange inputs to the limit codes
	// The range flags win over the code, which means nothing when either is set
	always_comb begin
		clamped = sample_code;
		if (!diff && sample_over)
			clamped = SE12_MAX;
		else if (!diff && sample_under)
			clamped = SE12_MIN;
		else if (diff && sample_over)
			clamped = DF12_MAX;
		else if (diff && sample_under)
			clamped = DF12_MIN;
	end

	// Widen to a signed value: differential is sign-extended, single-ended zero-extended
	// The extra bit keeps single-ended codes positive inside the signed sum
	always_comb begin
		if (diff)
			sample_ext = signed'({clamped[11], clamped});
		else
			sample_ext = signed'({1'b0, clamped});
	end

	// Running sum; first sample of a conversion restarts from zero
	// 23 bits hold 128 signed 13-bit values without overflow
	always_comb begin
		if (sample_first)
			acc_nxt = 23'({{10{sample_ext[12]}}, sample_ext});
		else
			acc_nxt = acc_r + 23'({{10{sample_ext[12]}}, sample_ext});
	end

	// A conversion completes on its 2**n-th sample, counted from the first one
	assign target = 8'(8'd1 << count_r);
	assign last   = sample_valid && ((sample_first ? 8'd1 : done_cnt_r + 8'd1) == target);

	// A sum of 2**n codes spans 12+n bits; this shift brings its top bit to bit 15
	assign left_shift = 3'(TRUNC_ABOVE_LOG2) - count_r;

	// Formatting of the finished sum
	// Single samples use fixed layouts; sums of 2..16 samples keep every bit
	always_comb begin
		logic [22:0] sum;
		logic [15:0] val;
		logic        sgn;
		sum = acc_nxt;
		sgn = diff & sum[22];
		val = 16'h0000;
		if (count_r == 3'd0) begin
			if (res10) begin
				// 10-bit: drop the two lowest conversion bits
				val = diff ? {{6{sgn}}, sum[11:2]} : {6'h00, sum[11:2]};
				if (left)
					val = {sum[11:2], 6'h00};
			end else begin
				val = diff ? {{4{sgn}}, sum[11:0]} : {4'h0, sum[11:0]};
				if (left)
					val = {sum[11:0], 4'h0};
			end
		end else if (count_r > 3'(TRUNC_ABOVE_LOG2)) begin
			// More than 16 samples: shift out low bits to fit 16 bits
			// Left alignment has no effect here: the truncated sum fills all 16 bits
			val = 16'(sum >> (count_r - 3'(TRUNC_ABOVE_LOG2)));
		end else begin
			val = 16'(sum);
			if (diff)
				for (int i = 0; i < 16; i++)
					if (i > 12 + int'(count_r))
						val[i] = sgn;
			// Left alignment puts the eight top sum bits in the high byte
			if (left)
				val = 16'(val << left_shift);
		end
		result_nxt = val;
	end

	// Counter restarts at every first sample, so a cut conversion never leaks onward
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_r      <= 23'h00_0000;
			done_cnt_r <= 8'h00;
		end else if (sample_valid) begin
			acc_r      <= acc_nxt;
			done_cnt_r <= last ? 8'h00 : (sample_first ? 8'd1 : done_cnt_r + 8'd1);
		end
	end

	// Result changes only on completion, so a partial sum is never visible
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			result_r <= RESULT_RESET;
		else if (last)
			result_r <= result_nxt;
	end

	// Interrupt status: set wins over clear
	// Overrun marks a completion that lands while the ready bit is still pending
	assign set_ev[IRQ_RESULT_READY_FLAG_BIT] = last;
	assign set_ev[IRQ_OVRUN_BIT]  = last && status_r[IRQ_RESULT_READY_FLAG_BIT];
	// A write commits once both halves are held and the previous response is gone
	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
	assign clr_ev  = (wr_fire && aw_addr_r == ADDR_IRQ_CLEAR && w_strb_r[0])
		? w_data_r[IRQ_W-1:0] : '0;

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			status_r <= '0;
		else
			status_r <= set_ev | (status_r & ~clr_ev);
	end

	// Flag and irq follow the next status value, so they rise with the status bit
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_ready_flag <= 1'b0;
			irq               <= 1'b0;
		end else begin
			result_ready_flag <= set_ev[IRQ_RESULT_READY_FLAG_BIT]
				| (status_r[IRQ_RESULT_READY_FLAG_BIT] & ~clr_ev[IRQ_RESULT_READY_FLAG_BIT]);
			irq <= |((set_ev | (status_r & ~clr_ev)) & enable_r);
		end
	end

	// AXI write: address and data taken in either order
	// Each ready is a one-cycle pulse; the held copy waits until both halves are in
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_have_r     <= 1'b0;
			aw_addr_r     <= 12'h000;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			w_have_r     <= 1'b0;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// Response goes out the cycle after the write commits and stands until bready
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr_r)
				ADDR_CONTROL_A, ADDR_CONTROL_B, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR:
					s_axi_bresp <= RESP_OKAY;
				// Read-only registers drop the write but still answer OKAY
				ADDR_RESULT, ADDR_IRQ_STATUS:
					s_axi_bresp <= RESP_OKAY;
				default:
					s_axi_bresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control registers steer the formatting
	// Only byte lane 0 carries fields; a count above COUNT_SEL_MAX is refused
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctla_r   <= CTLA_RESET;
			count_r  <= COUNT_RESET;
			enable_r <= '0;
		end else if (wr_fire && w_strb_r[0]) begin
			case (aw_addr_r)
				ADDR_CONTROL_A:  ctla_r <= w_data_r[2:0];
				ADDR_CONTROL_B: begin
					if (int'(w_data_r[CTLB_COUNT_LSB +: CTLB_COUNT_W]) <= COUNT_SEL_MAX)
						count_r <= w_data_r[CTLB_COUNT_LSB +: CTLB_COUNT_W];
				end
				ADDR_IRQ_ENABLE: enable_r <= w_data_r[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Registered copies of the settings for the converter sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			differential_select       <= 1'b0;
			resolution_select         <= 1'b0;
			accumulation_count_select <= COUNT_RESET;
		end else begin
			differential_select       <= diff;
			resolution_select         <= res10;
			accumulation_count_select <= count_r;
		end
	end

	// AXI read
	// No new address is taken while read data waits for rready
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				case (s_axi_araddr)
					ADDR_CONTROL_A:  s_axi_rdata <= {29'h0, ctla_r};
					ADDR_CONTROL_B:  s_axi_rdata <= {29'h0, count_r};
					ADDR_RESULT:     s_axi_rdata <= {16'h0000, result_r};
					ADDR_IRQ_STATUS: s_axi_rdata <= {30'h0, status_r};
					ADDR_IRQ_ENABLE: s_axi_rdata <= {30'h0, enable_r};
					ADDR_IRQ_CLEAR:  s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ### verilog/arf_pkg.sv
// Constants for the converter result formatter: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
package arf_pkg;
	localparam logic [11:0] ADDR_CONTROL_A  = 12'h000;
	localparam logic [11:0] ADDR_CONTROL_B  = 12'h004;
	localparam logic [11:0] ADDR_RESULT     = 12'h008;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h010;
	localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h014;
	// Control A field positions
	localparam int CTLA_DIFF_BIT  = 0;
	localparam int CTLA_LEFT_BIT  = 1;
	localparam int CTLA_RES10_BIT = 2;
	// Control B field: accumulation count select, 2**n samples
	localparam int CTLB_COUNT_LSB = 0;
	localparam int CTLB_COUNT_W   = 3;
	// Status bits
	localparam int IRQ_RESULT_READY_FLAG_BIT = 0;
	localparam int IRQ_OVRUN_BIT  = 1;
	localparam int IRQ_W          = 2;
	localparam logic [2:0]  CTLA_RESET   = 3'h0;
	localparam logic [2:0]  COUNT_RESET  = 3'h0;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;
	// Codes and limits
	localparam logic [11:0] SE12_MAX  = 12'hFFF;
	localparam logic [11:0] SE12_MIN  = 12'h000;
	localparam logic [11:0] DF12_MAX  = 12'h7FF;
	localparam logic [11:0] DF12_MIN  = 12'h800;
	localparam int          TRUNC_ABOVE_LOG2 = 4;
endpackage

// ### verif/arf_formatter_monitor.sv
// Checker for the result formatter: bus handshakes and result-ready timing.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/100ps
module arf_formatter_monitor #(
	parameter int COUNT_SEL_MAX = 6
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        sample_valid,
	input wire logic        sample_first,
	input wire logic [2:0]  accumulation_count_select,
	input wire logic        result_ready_flag,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready not a pulse");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready not a pulse");
	a_single_ready: assert property (sample_valid && sample_first && accumulation_count_select == 3'h0 |-> ##2 result_ready_flag)
		else $error("ready flag missing after single sample");
	a_ready_cause: assert property ($rose(result_ready_flag) |-> $past(sample_valid))
		else $error("ready flag without sample");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
endmodule

// ### verif/arf_formatter_test.sv
// Self-checking bench for the result formatter over its AXI4-Lite port.
// Drives raw samples directly; expects the register map of arf_pkg.
`timescale 1ns/100ps
module arf_formatter_test;
	import arf_pkg::*;
	logic clk, reset, sv, sf, so, su, irq, rflag, dsel, rsel;
	logic [11:0] sc, awaddr, araddr;
	logic [2:0] csel;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	int miscompares, n_compared, cyc;
	arf_formatter dut (.clk(clk), .reset(reset), .sample_valid(sv), .sample_first(sf),
		.sample_code(sc), .sample_over(so), .sample_under(su), .differential_select(dsel),
		.resolution_select(rsel), .accumulation_count_select(csel), .result_ready_flag(rflag),
		.irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		araddr <= a; arvalid <= 1; rready <= 1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	task automatic conv(input int n, input logic [11:0] c, input logic ov, input logic un);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			sv <= 1; sf <= (i == 0); sc <= c; so <= ov; su <= un;
		end
		@(posedge clk);
		sv <= 0; sf <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic one(input logic [2:0] m, input logic [11:0] c, input logic ov, input logic un,
		input logic [15:0] e);
		wr(ADDR_CONTROL_A, {29'h0, m});
		conv(1, c, ov, un);
		rd(ADDR_RESULT);
		chk("result", {16'h0000, e}, d);
		chk("diff select", {31'h0, m[0]}, {31'h0, dsel});
		chk("res select", {31'h0, m[2]}, {31'h0, rsel});
	endtask
	initial begin
		reset = 1; sv = 0; sf = 0; sc = 0; so = 0; su = 0; awaddr = 0; araddr = 0; wdata = 0;
		wstrb = 4'hF; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		repeat (8) @(posedge clk);
		reset <= 0;
		rd(ADDR_RESULT); chk("result reset", 32'h0000_0000, d);
		chk("result rresp", {30'h0, RESP_OKAY}, {30'h0, r});
		rd(12'h100); chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(12'h100, 32'h0000_0001); chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(ADDR_CONTROL_B, 32'h0000_0000);
		chk("control bresp", {30'h0, RESP_OKAY}, {30'h0, r});
		one(3'h0, 12'hABC, 0, 0, 16'h0ABC);
		one(3'h2, 12'hABC, 0, 0, 16'hABC0);
		one(3'h0, 12'h123, 1, 0, 16'h0FFF);
		one(3'h0, 12'h123, 0, 1, 16'h0000);
		one(3'h1, 12'h800, 0, 0, 16'hF800);
		one(3'h1, 12'h123, 1, 0, 16'h07FF);
		one(3'h1, 12'h123, 0, 1, 16'hF800);
		one(3'h4, 12'hABC, 0, 0, 16'h02AF);
		one(3'h5, 12'h800, 0, 0, 16'hFE00);
		wr(ADDR_RESULT, 32'h0000_1234);
		rd(ADDR_RESULT); chk("result read-only", 32'h0000_FE00, d);
		wr(ADDR_CONTROL_A, 32'h0000_0000);
		wr(ADDR_CONTROL_B, 32'h0000_0002);
		conv(4, 12'h100, 0, 0); conv(4, 12'h100, 0, 0);
		rd(ADDR_RESULT); chk("sum of 4", 32'h0000_0400, d);
		chk("count select", 32'h2, {29'h0, csel});
		wr(ADDR_CONTROL_A, 32'h0000_0001);
		conv(4, 12'h800, 0, 0);
		rd(ADDR_RESULT);
		chk("diff sum of 4", 32'h0000_E000, d);
		wr(ADDR_CONTROL_A, 32'h0000_0002);
		wr(ADDR_CONTROL_B, 32'h0000_0001);
		conv(2, 12'hFFF, 0, 0);
		rd(ADDR_RESULT);
		chk("left sum of 2", 32'h0000_FFF0, d);
		wr(ADDR_CONTROL_B, 32'h0000_0004);
		conv(16, 12'hFFF, 0, 0);
		rd(ADDR_RESULT);
		chk("left sum of 16", 32'h0000_FFF0, d);
		wr(ADDR_CONTROL_A, 32'h0000_0000);
		wr(ADDR_CONTROL_B, 32'h0000_0005);
		conv(32, 12'hFFF, 0, 0);
		rd(ADDR_RESULT); chk("sum of 32", 32'h0000_FFF0, d);
		wr(ADDR_CONTROL_B, 32'h0000_0007);
		wstrb <= 4'h0;
		wr(ADDR_CONTROL_B, 32'h0000_0003);
		chk("lane 0 off bresp", {30'h0, RESP_OKAY}, {30'h0, r});
		wstrb <= 4'hF;
		rd(ADDR_CONTROL_B);
		chk("count refused", 32'h0000_0005, d);
		rd(ADDR_IRQ_STATUS); chk("status overrun", 32'h0000_0003, d);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_CLEAR, 32'h0000_0003);
		rd(ADDR_IRQ_STATUS); chk("status cleared", 32'h0000_0000, d);
		wr(ADDR_IRQ_ENABLE, 32'h0000_0001);
		wr(ADDR_CONTROL_B, 32'h0000_0000);
		conv(1, 12'h001, 0, 0);
		chk("irq raised", 32'h1, {31'h0, irq});
		chk("ready flag", 32'h1, {31'h0, rflag});
		wr(ADDR_IRQ_CLEAR, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		stop_test();
	end
endmodule
bind arf_formatter arf_formatter_monitor #(.COUNT_SEL_MAX(COUNT_SEL_MAX)) mon (.clk(clk),
	.reset(reset), .sample_valid(sample_valid), .sample_first(sample_first),
	.accumulation_count_select(accumulation_count_select), .result_ready_flag(result_ready_flag),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata));
